// File: rtl/clk_irq_rst_pkg.sv
// Constants, register map and carrier types of the clock interrupt and peripheral reset block
package clk_irq_rst_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] CLOCK_CONTROL_OFF = 12'h000;
  localparam logic [11:0] CLOCK_INTERRUPT_CONTROL_OFF = 12'h008;
  localparam logic [11:0] FAST_BUS_PERIPHERAL_RESET_OFF = 12'h00c;
  localparam logic [11:0] SLOW_BUS_PERIPHERAL_RESET_OFF = 12'h010;
  localparam logic [31:0] REG_RESET_VALUE = 32'h00000000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int N_SRC = 5;
  localparam int READY_FLAG_LSB = 0;
  localparam int FAIL_FLAG_BIT = 7;
  localparam int READY_IRQ_ON_LSB = 8;
  localparam int READY_CLEAR_LSB = 16;
  localparam int FAIL_CLEAR_BIT = 23;
  localparam int FAIL_DETECTOR_ON_BIT = 19;

  // Writable bits of the two reset registers
  localparam logic [31:0] SLOW_BUS_RESET_MASK = 32'h127e_4a0f;
  localparam logic [31:0] FAST_BUS_RESET_MASK = 32'h0038_5abf;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic pll;
    logic fastXtal;
    logic fastRc;
    logic slowXtal;
    logic slowRc;
  } clk_ready_s;

  typedef struct packed {
    logic powerCtlUnitReset;
    logic canCtlReset;
    logic secondI2cReset;
    logic firstI2cReset;
    logic [3:0] serialPortReset;
    logic secondSpiReset;
    logic windowWatchdogReset;
    logic comparatorReset;
    logic [3:0] timerReset;
  } slow_rst_s;

  typedef struct packed {
    logic [2:0] timerReset;
    logic serialPort1Reset;
    logic firstSpiReset;
    logic advTimerReset;
    logic converterReset;
    logic portFReset;
    logic portDReset;
    logic portCReset;
    logic portBReset;
    logic portAReset;
    logic extIrqUnitReset;
    logic pinRemapReset;
  } fast_rst_s;

endpackage

// File: rtl/ready_flag_cell.sv
// Sticky flag set on a rising edge of a qualified level, cleared by software
`timescale 1ns/1ps
module ready_flag_cell
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic level,
  input wire logic arm,
  input wire logic clear,
  output logic flag
);

  logic prevLevel_ff;
  logic flag_ff;
  wire logic rise;
  wire logic nxt_flag;

  // Edge, not level: a flag cleared while the source stays ready stays clear
  assign rise = level & ~prevLevel_ff & arm;
  // Set beats a simultaneous clear so no event is lost
  assign nxt_flag = rise | (flag_ff & ~clear);
  assign flag = flag_ff;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prevLevel_ff <= 1'b0;
      flag_ff <= 1'b0;
    end
    else
    begin
      prevLevel_ff <= level;
      flag_ff <= nxt_flag;
    end
  end

endmodule

// File: rtl/clock_irq_and_periph_reset.sv
// Clock ready interrupt flags, clock failure flag and peripheral reset lines
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module clock_irq_and_periph_reset
#(
  parameter int ADDR_W = clk_irq_rst_pkg::ADDR_W
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  input wire clk_irq_rst_pkg::clk_ready_s clkReady,
  input wire logic fastXtalFail,
  output logic clkIrq,
  output logic failDetectorOn,
  output clk_irq_rst_pkg::slow_rst_s slowBusReset,
  output clk_irq_rst_pkg::fast_rst_s fastBusReset
);

  // ****************************************
  // Address decode
  // ****************************************
  wire logic selCtrl;
  wire logic selInt;
  wire logic selFast;
  wire logic selSlow;
  wire logic wrCtrl;
  wire logic wrInt;
  wire logic wrFast;
  wire logic wrSlow;

  assign selCtrl = addr == ADDR_W'(clk_irq_rst_pkg::CLOCK_CONTROL_OFF);
  assign selInt = addr == ADDR_W'(clk_irq_rst_pkg::CLOCK_INTERRUPT_CONTROL_OFF);
  assign selFast = addr == ADDR_W'(clk_irq_rst_pkg::FAST_BUS_PERIPHERAL_RESET_OFF);
  assign selSlow = addr == ADDR_W'(clk_irq_rst_pkg::SLOW_BUS_PERIPHERAL_RESET_OFF);

  // ****************************************
  // Write strobes
  // ****************************************
  // Strobes qualified by a whole-word address match
  assign wrCtrl = wrStb & selCtrl;
  assign wrInt = wrStb & selInt;
  assign wrFast = wrStb & selFast;
  assign wrSlow = wrStb & selSlow;

  // ****************************************
  // Access qualification
  // ****************************************
  wire logic hitAny;
  wire logic rdHit;

  // Reads of unmapped offsets return zero, never stale data
  assign hitAny = selCtrl | selInt | selFast | selSlow;
  assign rdHit = rdStb & hitAny;

  // ****************************************
  // Storage
  // ****************************************
  // Software-owned state
  logic detectorOn_ff;
  logic [clk_irq_rst_pkg::N_SRC-1:0] readyIrqOn_ff;
  logic [31:0] fastReset_ff;
  logic [31:0] slowReset_ff;

  // Registered outputs
  logic [31:0] rdData_ff;
  logic irq_ff;

  wire logic nxt_detectorOn;
  wire logic [clk_irq_rst_pkg::N_SRC-1:0] nxt_readyIrqOn;
  wire logic [31:0] nxt_fastReset;
  wire logic [31:0] nxt_slowReset;

  // ****************************************
  // Next register values
  // ****************************************
  // Each value holds unless its own register is written

  assign nxt_detectorOn = wrCtrl ? wrData[clk_irq_rst_pkg::FAIL_DETECTOR_ON_BIT] : detectorOn_ff;
  assign nxt_readyIrqOn = wrInt
    ? wrData[clk_irq_rst_pkg::READY_IRQ_ON_LSB +: clk_irq_rst_pkg::N_SRC]
    : readyIrqOn_ff;

  // ****************************************
  // Write data masking
  // ****************************************
  // Reserved bits never store, so they always read zero
  assign nxt_fastReset = wrFast ? (wrData & clk_irq_rst_pkg::FAST_BUS_RESET_MASK) : fastReset_ff;
  assign nxt_slowReset = wrSlow ? (wrData & clk_irq_rst_pkg::SLOW_BUS_RESET_MASK) : slowReset_ff;

  // ****************************************
  // Register updates
  // ****************************************
  // Separate processes keep every reset path short
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      detectorOn_ff <= 1'b0;
    end
    else
    begin
      detectorOn_ff <= nxt_detectorOn;
    end
  end

  // Interrupt enables start disabled
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      readyIrqOn_ff <= '0;
    end
    else
    begin
      readyIrqOn_ff <= nxt_readyIrqOn;
    end
  end

  // Reset lines come out of reset released
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      fastReset_ff <= clk_irq_rst_pkg::REG_RESET_VALUE;
    end
    else
    begin
      fastReset_ff <= nxt_fastReset;
    end
  end

  // Slow bus lines likewise
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      slowReset_ff <= clk_irq_rst_pkg::REG_RESET_VALUE;
    end
    else
    begin
      slowReset_ff <= nxt_slowReset;
    end
  end

  // ****************************************
  // Ready and failure flags
  // ****************************************
  wire logic [clk_irq_rst_pkg::N_SRC-1:0] readyLevel;
  wire logic [clk_irq_rst_pkg::N_SRC-1:0] readyClear;
  wire logic [clk_irq_rst_pkg::N_SRC-1:0] readyFlag;
  wire logic failClear;
  wire logic failFlag;

  // Bit 4 pll, 3 fast crystal, 2 fast RC, 1 slow crystal, 0 slow RC
  assign readyLevel = clkReady;

  // ****************************************
  // Clear strobes
  // ****************************************
  // Clear bits act only on a write of one; zeros leave flags alone
  generate
    for (genvar c = 0; c < clk_irq_rst_pkg::N_SRC; c++)
    begin : g_clear
      assign readyClear[c] = wrInt & wrData[clk_irq_rst_pkg::READY_CLEAR_LSB + c];
    end
  endgenerate
  assign failClear = wrInt & wrData[clk_irq_rst_pkg::FAIL_CLEAR_BIT];

  // ****************************************
  // Ready flag cells
  // ****************************************
  // Edge detection lives in each cell
  generate
    for (genvar i = 0; i < clk_irq_rst_pkg::N_SRC; i++)
    begin : g_ready
      ready_flag_cell u_cell
      (
        .mclk(mclk),
        .srst(srst),
        .level(readyLevel[i]),
        .arm(1'b1),
        .clear(readyClear[i]),
        .flag(readyFlag[i])
      );
    end
  endgenerate

  // ****************************************
  // Failure flag cell
  // ****************************************
  // Failures are only seen while the detector is switched on,
  // and a flag already set survives the detector being turned off
  ready_flag_cell u_fail
  (
    .mclk(mclk),
    .srst(srst),
    .level(fastXtalFail),
    .arm(detectorOn_ff),
    .clear(failClear),
    .flag(failFlag)
  );

  // ****************************************
  // Interrupt request
  // ****************************************
  wire logic [clk_irq_rst_pkg::N_SRC-1:0] readyPending;
  wire logic anyReadyPending;
  wire logic nxt_irq;

  // ****************************************
  // Pending sources
  // ****************************************
  // The failure flag has no enable of its own
  assign readyPending = readyFlag & readyIrqOn_ff;
  assign anyReadyPending = |readyPending;
  assign nxt_irq = anyReadyPending | failFlag;

  // ****************************************
  // Request register
  // ****************************************
  // Registered so the request line never glitches
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire logic [31:0] ctrlView;
  wire logic [31:0] intEnableField;
  wire logic [31:0] intFailField;
  wire logic [31:0] intFlagField;
  wire logic [31:0] intView;

  wire logic [31:0] ctrlPart;
  wire logic [31:0] intPart;
  wire logic [31:0] fastPart;
  wire logic [31:0] slowPart;

  wire logic [31:0] rdMux;
  wire logic [31:0] nxt_rdData;

  // Only the detector enable lives in the control word
  assign ctrlView = 32'(detectorOn_ff) << clk_irq_rst_pkg::FAIL_DETECTOR_ON_BIT;

  // Clear bits are write-only and read back as zero
  assign intEnableField = 32'(readyIrqOn_ff) << clk_irq_rst_pkg::READY_IRQ_ON_LSB;
  assign intFailField = 32'(failFlag) << clk_irq_rst_pkg::FAIL_FLAG_BIT;
  assign intFlagField = 32'(readyFlag) << clk_irq_rst_pkg::READY_FLAG_LSB;
  assign intView = intEnableField | intFailField | intFlagField;

  // ****************************************
  // Read select
  // ****************************************
  // Selects are one-hot, so an OR of gated views needs no priority chain
  assign ctrlPart = {32{selCtrl}} & ctrlView;
  assign intPart = {32{selInt}} & intView;
  assign fastPart = {32{selFast}} & fastReset_ff;
  assign slowPart = {32{selSlow}} & slowReset_ff;
  assign rdMux = ctrlPart | intPart | fastPart | slowPart;

  // Unmapped offsets fall through to zero
  // Data stand only in the cycle after the strobe, zero otherwise
  assign nxt_rdData = rdHit ? rdMux : 32'h00000000;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rdData_ff <= 32'h00000000;
    end
    else
    begin
      rdData_ff <= nxt_rdData;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a flop or a slice of one
  assign rdData = rdData_ff;
  assign clkIrq = irq_ff;
  assign failDetectorOn = detectorOn_ff;

  // ****************************************
  // Slow bus reset lines
  // ****************************************
  // Each line holds its unit in reset while its bit is one
  assign slowBusReset.powerCtlUnitReset = slowReset_ff[28];
  assign slowBusReset.canCtlReset = slowReset_ff[25];
  assign slowBusReset.secondI2cReset = slowReset_ff[22];
  assign slowBusReset.firstI2cReset = slowReset_ff[21];
  assign slowBusReset.secondSpiReset = slowReset_ff[14];
  assign slowBusReset.windowWatchdogReset = slowReset_ff[11];
  assign slowBusReset.comparatorReset = slowReset_ff[9];

  // Serial ports and timers two to five, lowest unit at the lowest bit
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_slow_multi
      assign slowBusReset.serialPortReset[p] = slowReset_ff[17 + p];
      assign slowBusReset.timerReset[p] = slowReset_ff[p];
    end
  endgenerate

  // ****************************************
  // Fast bus reset lines
  // ****************************************
  // Three timers at the top of the field
  generate
    for (genvar t = 0; t < 3; t++)
    begin : g_fast_timer
      assign fastBusReset.timerReset[t] = fastReset_ff[19 + t];
    end
  endgenerate

  // Single units, one bit each
  assign fastBusReset.serialPort1Reset = fastReset_ff[14];
  assign fastBusReset.firstSpiReset = fastReset_ff[12];
  assign fastBusReset.advTimerReset = fastReset_ff[11];
  assign fastBusReset.converterReset = fastReset_ff[9];
  assign fastBusReset.portFReset = fastReset_ff[7];
  assign fastBusReset.portDReset = fastReset_ff[5];
  assign fastBusReset.portCReset = fastReset_ff[4];
  assign fastBusReset.portBReset = fastReset_ff[3];
  assign fastBusReset.portAReset = fastReset_ff[2];
  assign fastBusReset.extIrqUnitReset = fastReset_ff[1];
  assign fastBusReset.pinRemapReset = fastReset_ff[0];

endmodule

// File: verif/clock_irq_and_periph_reset_asserts.sv
// Port-level assertion checker for the clock interrupt and peripheral reset block
`timescale 1ns/1ps
module clock_irq_and_periph_reset_asserts
#(
  parameter int ADDR_W = 12
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [31:0] rdData,
  input wire clk_irq_rst_pkg::clk_ready_s clkReady,
  input wire logic fastXtalFail,
  input wire logic clkIrq,
  input wire logic failDetectorOn,
  input wire clk_irq_rst_pkg::slow_rst_s slowBusReset,
  input wire clk_irq_rst_pkg::fast_rst_s fastBusReset
);
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  wire isInt = (addr == 12'h008);
  wire isSlow = (addr == 12'h010);
  sequence wrInt;
    wrStb && isInt;
  endsequence
  sequence rdInt;
    rdStb && isInt;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_slow_rst_map: assert property (wrStb && isSlow |=> slowBusReset == {$past(wrData[28]), $past(wrData[25]),
    $past(wrData[22:17]), $past(wrData[14]), $past(wrData[11]), $past(wrData[9]), $past(wrData[3:0])})
    else $error("slow bus reset lines differ from written word");
  a_fast_rst_map: assert property (wrStb && addr == 12'h00c |=> fastBusReset == {$past(wrData[21:19]),
    $past(wrData[14]), $past(wrData[12:11]), $past(wrData[9]), $past(wrData[7]), $past(wrData[5:0])})
    else $error("fast bus reset lines differ from written word");
  a_rst_lines_hold: assert property (!(wrStb && isSlow) |=> $stable(slowBusReset))
    else $error("slow bus reset lines moved without a write");
  a_detector_write: assert property (wrStb && addr == 12'h000 |=> failDetectorOn == $past(wrData[19]))
    else $error("detector enable does not follow write");
  a_fail_irq: assert property ($rose(fastXtalFail) && failDetectorOn |-> ##2 clkIrq)
    else $error("failure edge did not raise the request");
  a_clear_reads_zero: assert property ($past(rdStb) && $past(addr) == 12'h008 |-> rdData[31:16] == 16'h0000)
    else $error("clear or reserved bits read nonzero");
  a_ien_readback: assert property (wrInt ##1 !wrStb ##1 rdInt |=> rdData[12:8] == $past(wrData[12:8], 3))
    else $error("interrupt enables not read back");
  a_pll_flag_read: assert property ($rose(clkReady.pll) ##1 rdInt |=> rdData[4])
    else $error("ready flag not set after ready edge");
  a_pll_clear: assert property ((wrInt and (wrData[20] && !$rose(clkReady.pll)))
    ##1 (!wrStb && $stable(clkReady.pll)) ##1 (rdInt and $stable(clkReady.pll)) |=> !rdData[4])
    else $error("ready flag survived its clear");
endmodule
bind clock_irq_and_periph_reset clock_irq_and_periph_reset_asserts #(.ADDR_W(ADDR_W)) chk_u (.mclk(mclk),
  .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .clkReady(clkReady), .fastXtalFail(fastXtalFail), .clkIrq(clkIrq), .failDetectorOn(failDetectorOn),
  .slowBusReset(slowBusReset), .fastBusReset(fastBusReset));

// File: verif/clk_src_model.sv
// Oscillator, PLL and failure detector stand-in with a short settling delay
`timescale 1ns/1ps
module clk_src_model
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [4:0] readyReq,
  input wire logic failReq,
  output clk_irq_rst_pkg::clk_ready_s clkReady,
  output logic fastXtalFail
);
  // Two stages mimic startup, so ready never lines up with the request edge
  logic [5:0] settle_ff;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      settle_ff <= 6'h00;
      clkReady <= '0;
      fastXtalFail <= 1'b0;
    end
    else
    begin
      settle_ff <= {failReq, readyReq};
      clkReady <= settle_ff[4:0];
      fastXtalFail <= settle_ff[5];
    end
  end
endmodule

// File: verif/clock_irq_and_periph_reset_tb_top.sv
// Self-checking testbench for the clock interrupt and peripheral reset block
`timescale 1ns/1ps
module clock_irq_and_periph_reset_tb_top;
  localparam logic [31:0] SLOW_RW = 32'h127e_4a0f;
  localparam logic [31:0] FAST_RW = 32'h0038_5abf;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wrData = 32'h0000_0000;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [4:0] readyReq = 5'h00;
  logic failReq = 1'b0;
  logic [31:0] rdData;
  clk_irq_rst_pkg::clk_ready_s clkReady;
  logic fastXtalFail;
  logic clkIrq;
  logic failDetectorOn;
  clk_irq_rst_pkg::slow_rst_s slowBusReset;
  clk_irq_rst_pkg::fast_rst_s fastBusReset;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2 mclk = ~mclk;
  clock_irq_and_periph_reset dut_u (.mclk(mclk), .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .clkReady(clkReady), .fastXtalFail(fastXtalFail), .clkIrq(clkIrq),
    .failDetectorOn(failDetectorOn), .slowBusReset(slowBusReset), .fastBusReset(fastBusReset));
  clk_src_model src_u (.mclk(mclk), .srst(srst), .readyReq(readyReq), .failReq(failReq),
    .clkReady(clkReady), .fastXtalFail(fastXtalFail));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wrStb <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rdStb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 check(rdData, exp);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bounded wait on one source level, index 5 is the failure line
  task automatic wait_src(input int i, input logic lvl);
    logic [5:0] v;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      #1 v = {fastXtalFail, clkReady};
      if (v[i] === lvl)
        return;
    end
    error_cnt++;
    wrap_up();
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(12'h008, 32'h0);
    rd_chk(12'h00c, 32'h0);
    rd_chk(12'h010, 32'h0);
    wr(12'h004, 32'hffff_ffff);
    rd_chk(12'h004, 32'h0);
    $display("Reset values test done");
    for (int i = 0; i < 32; i++)
    begin
      wr(12'h010, 32'h1 << i);
      rd_chk(12'h010, (32'h1 << i) & SLOW_RW);
      wr(12'h00c, 32'h1 << i);
      rd_chk(12'h00c, (32'h1 << i) & FAST_RW);
    end
    wr(12'h010, 32'h1000_0000);
    #1 check({17'h0, slowBusReset}, 32'h4000);
    wr(12'h010, 32'h0);
    #1 check({17'h0, slowBusReset}, 32'h0);
    wr(12'h00c, 32'h0000_0800);
    #1 check({18'h0, fastBusReset}, 32'h100);
    wr(12'h00c, 32'h0);
    #1 check({18'h0, fastBusReset}, 32'h0);
    $display("Reset lines test done");
    for (int i = 0; i < 5; i++)
    begin
      readyReq[i] <= 1'b1;
      wait_src(i, 1'b1);
      rd_chk(12'h008, 32'h1 << i);
      check({31'h0, clkIrq}, 32'h0);
      wr(12'h008, 32'h100 << i);
      repeat (2) @(posedge mclk);
      #1 check({31'h0, clkIrq}, 32'h1);
      rd_chk(12'h008, 32'h101 << i);
      wr(12'h008, 32'h10100 << i);
      rd_chk(12'h008, 32'h100 << i);
      check({31'h0, clkIrq}, 32'h0);
      wr(12'h008, 32'h0);
      readyReq[i] <= 1'b0;
      wait_src(i, 1'b0);
      rd_chk(12'h008, 32'h0);
    end
    $display("Ready flags test done");
    failReq <= 1'b1;
    wait_src(5, 1'b1);
    failReq <= 1'b0;
    rd_chk(12'h008, 32'h0);
    wr(12'h000, 32'h0008_0000);
    rd_chk(12'h000, 32'h0008_0000);
    check({31'h0, failDetectorOn}, 32'h1);
    failReq <= 1'b1;
    wait_src(5, 1'b1);
    failReq <= 1'b0;
    rd_chk(12'h008, 32'h80);
    check({31'h0, clkIrq}, 32'h1);
    wr(12'h008, 32'h0);
    rd_chk(12'h008, 32'h80);
    wr(12'h008, 32'h0080_0000);
    rd_chk(12'h008, 32'h0);
    check({31'h0, clkIrq}, 32'h0);
    $display("Clock failure test done");
    wrap_up();
  end
endmodule
